// file: sim/fll_dco_lock_loop_test.sv
`timescale 1ns/10ps
`include "fll_dco_regs.svh"
module fll_dco_lock_loop_test;
    import fll_dco_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic ref_clk, osc_tick, loop_en, osc_en, pulse, short_en;
    power_mode_t mode = `PM_LOW_POWER_MODE_ONE;
    logic gen_off = 1'b0, f_aux = 1'b0, f_sub = 1'b0, tmr = 1'b0;
    logic [15:0] target = 16'h0100;
    logic [4:0] tap, modf;
    logic [15:0] last;
    int err_total = 0;
    int compares = 0;
    int n;
    // 200 MHz system clock
    always #2.5 i_clk_sys = ~i_clk_sys;
    fll_ref_osc_model #(.REF_HALF(20), .OSC_HALF(2)) far_side (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_osc_run(osc_en),
        .o_ref_clk(ref_clk), .o_osc_tick(osc_tick));
    fll_dco_lock_loop DUT (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ref_clk(ref_clk),
        .i_osc_tick(osc_tick), .i_power_mode(mode),
        .i_clock_generator_off_bit(gen_off), .i_osc_feeds_aux(f_aux),
        .i_osc_feeds_subsystem_clock(f_sub), .i_timer_on_osc_clock(tmr),
        .i_target_count(target), .o_loop_enabled(loop_en),
        .o_oscillator_enabled(osc_en), .o_oscillator_tap_field(tap),
        .o_oscillator_modulation_field(modf), .o_last_count(last),
        .o_correction_pulse(pulse), .o_short_enable(short_en));
    task check(input string name, input logic [15:0] seen,
               input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Mode inputs change on an edge; sample after the next edge settles
    task set_in(input power_mode_t m, input logic g, input logic a,
                input logic s, input logic t);
        @(posedge i_clk_sys);
        mode <= m;
        gen_off <= g;
        f_aux <= a;
        f_sub <= s;
        tmr <= t;
        @(posedge i_clk_sys);
        #1;
    endtask : set_in
    // Bounded wait for the one-cycle correction pulse, counting cycles
    task wait_pulse();
        n = 0;
        while (pulse !== 1'b1 && n < 1000)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
    endtask : wait_pulse
    task final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    // Watchdog: the sequence needs about 400 cycles
    initial
    begin
        #50000;
        err_total++;
        final_report();
    end
    initial
    begin
        repeat (5) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        @(posedge i_clk_sys);
        #1;
        check("tap reset", tap, `TAP_RESET);
        check("mod reset", modf, `MOD_RESET);
        check("short reset", short_en, 1'b0);
        set_in(`PM_LOW_POWER_MODE_ONE, 1'b0, 1'b0, 1'b0, 1'b0);
        for (int m = 3; m <= 5; m++)
        begin
            set_in(power_mode_t'(m), 1'b1, 1'b0, 1'b0, 1'b0);
            check("deep loop", loop_en, 1'b0);
            check("deep osc", osc_en, 1'b0);
        end
        set_in(`PM_LOW_POWER_MODE_ZERO, 1'b0, 1'b0, 1'b0, 1'b0);
        check("mode0 loop", loop_en, 1'b0);
        set_in(`PM_LOW_POWER_MODE_ZERO, 1'b0, 1'b1, 1'b0, 1'b0);
        check("mode0 aux loop", loop_en, 1'b1);
        set_in(`PM_LOW_POWER_MODE_ZERO, 1'b0, 1'b0, 1'b0, 1'b1);
        check("timer loop", loop_en, 1'b1);
        check("timer osc", osc_en, 1'b1);
        // Full cycle from a cold enable; count below target steps up
        set_in(`PM_LOW_POWER_MODE_ONE, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge i_clk_sys);
        mode <= `PM_ACTIVE;
        wait_pulse();
        check("cycle span", n >= 80 && n <= 130, 1'b1);
        check("count", last, 16'h000a);
        check("mod up", modf, 5'h01);
        check("tap kept", tap, 5'h10);
        @(posedge i_clk_sys);
        target <= 16'h0001;
        #1;
        check("pulse width", pulse, 1'b0);
        wait_pulse();
        check("mod down", modf, 5'h00);
        // Enable shorter than three reference cycles
        set_in(`PM_LOW_POWER_MODE_ONE, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge i_clk_sys);
        mode <= `PM_ACTIVE;
        repeat (50) @(posedge i_clk_sys);
        mode <= `PM_LOW_POWER_MODE_ONE;
        @(posedge i_clk_sys);
        #1;
        check("drift pulse", pulse, 1'b1);
        repeat (2) @(posedge i_clk_sys);
        #1;
        check("short set", short_en, 1'b1);
        check("short mod", modf, 5'h1f);
        check("short tap", tap, 5'h0f);
        // Stay enabled through three reference edges, up to the correction
        set_in(`PM_ACTIVE, 1'b0, 1'b0, 1'b0, 1'b0);
        wait_pulse();
        check("borrow tap", tap, 5'h0f);
        check("borrow mod", modf, 5'h1e);
        @(posedge i_clk_sys);
        #1;
        check("short clear", short_en, 1'b0);
        final_report();
    end
endmodule : fll_dco_lock_loop_test

// file: sim/fll_ref_osc_model.sv
`timescale 1ns/10ps
// Reference crystal and controlled oscillator seen from the loop
module fll_ref_osc_model #(
    parameter int REF_HALF = 20,
    parameter int OSC_HALF = 2
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_osc_run,
    output logic o_ref_clk,
    output logic o_osc_tick
);
    int ref_cnt;
    int osc_cnt;
    // Reference runs free; oscillator freezes while disabled, so no
    // ticks leak into a capture that the loop should not be making
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ref_cnt <= 0;
            osc_cnt <= 0;
            o_ref_clk <= 1'b0;
            o_osc_tick <= 1'b0;
        end
        else
        begin
            ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
            if (ref_cnt == REF_HALF - 1)
                o_ref_clk <= ~o_ref_clk;
            if (i_osc_run)
                osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
            if (i_osc_run && osc_cnt == OSC_HALF - 1)
                o_osc_tick <= ~o_osc_tick;
        end
    end
endmodule : fll_ref_osc_model

// file: src/fll_dco_lock_loop.sv
`timescale 1ns/10ps
`include "fll_dco_regs.svh"
module fll_dco_lock_loop #(
    parameter int CNT_W = 16,
    parameter int FIELD_W = 5
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ref_clk,
    input wire logic i_osc_tick,
    input wire fll_dco_pkg::power_mode_t i_power_mode,
    input wire logic i_clock_generator_off_bit,
    input wire logic i_osc_feeds_aux,
    input wire logic i_osc_feeds_subsystem_clock,
    input wire logic i_timer_on_osc_clock,
    input wire logic [CNT_W-1:0] i_target_count,
    output logic o_loop_enabled,
    output logic o_oscillator_enabled,
    output logic [FIELD_W-1:0] o_oscillator_tap_field,
    output logic [FIELD_W-1:0] o_oscillator_modulation_field,
    output logic [CNT_W-1:0] o_last_count,
    output logic o_correction_pulse,
    output logic o_short_enable
);
    import fll_dco_pkg::*;

    // Two-flop synchronisers for the pin-level inputs
    logic [2:0] ref_sync;
    logic [1:0] tick_sync;
    logic tick_prev;
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ref_sync <= 3'h0;
            tick_sync <= 2'h0;
            tick_prev <= 1'b0;
        end
        else
        begin
            ref_sync <= {ref_sync[1:0], i_ref_clk};
            tick_sync <= {tick_sync[0], i_osc_tick};
            tick_prev <= tick_sync[1];
        end
    end

    // Edge detect reads only the second and third stages
    logic ref_rise;
    logic tick_rise;
    assign ref_rise = ref_sync[1] & ~ref_sync[2];
    assign tick_rise = tick_sync[1] & ~tick_prev;

    // Enable decision from the power mode
    logic osc_used;
    logic loop_en;
    always_comb
    begin
        osc_used = i_osc_feeds_aux | i_osc_feeds_subsystem_clock;
        unique case (i_power_mode)
            `PM_ACTIVE: loop_en = 1'b1;
            `PM_LOW_POWER_MODE_ZERO: loop_en = osc_used | i_timer_on_osc_clock;
            `PM_LOW_POWER_MODE_ONE: loop_en = 1'b0;
            `PM_LOW_POWER_MODE_TWO, `PM_LPM3, `PM_LPM4:
                loop_en = ~i_clock_generator_off_bit;
            default: loop_en = 1'b0;
        endcase
    end
    assign o_loop_enabled = loop_en;
    // Oscillator stays up whenever the loop runs or the aux or subsystem clock uses it
    assign o_oscillator_enabled = loop_en | osc_used;

    // Measure and correct state
    loop_state_t state, next_state;
    logic [1:0] edges, next_edges;
    logic [CNT_W-1:0] count, next_count;
    logic [CNT_W-1:0] last, next_last;
    logic [FIELD_W-1:0] tap, next_tap;
    logic [FIELD_W-1:0] modf, next_modf;
    logic pulse, next_pulse;
    logic short_en, next_short_en;
    logic do_step;
    logic [CNT_W-1:0] step_cnt;

    // Loop sequencing; a disable past the first capture edge still steps the fields on
    // the partial count, which is the drift hazard of short enables
    always_comb
    begin
        next_state = state;
        next_edges = edges;
        next_count = count;
        next_last = last;
        next_tap = tap;
        next_modf = modf;
        next_pulse = 1'b0;
        next_short_en = short_en;
        do_step = 1'b0;
        step_cnt = last;
        if (tick_rise)
            next_count = count + `COUNT_ONE;
        unique case (state)
            st_off:
            begin
                if (loop_en)
                begin
                    next_state = st_capture;
                    next_edges = 2'h0;
                end
            end
            st_wait_first:
                next_state = st_capture;
            st_capture:
            begin
                if (ref_rise)
                begin
                    next_edges = edges + 2'h1;
                    if (edges + 2'h1 == `CAPTURE_EDGES)
                    begin
                        next_state = st_apply;
                        next_last = count;
                        next_edges = 2'h0;
                    end
                    // A tick on the reference edge opens the new window
                    next_count = tick_rise ? `COUNT_ONE : `COUNT_ZERO;
                end
            end
            st_apply:
            begin
                if (ref_rise && edges + 2'h1 == `APPLY_EDGES)
                begin
                    do_step = 1'b1;
                    next_state = st_capture;
                    next_edges = 2'h0;
                    next_short_en = 1'b0;
                    next_count = tick_rise ? `COUNT_ONE : `COUNT_ZERO;
                end
            end
        endcase
        // Disable mid-capture past the first edge corrects on the partial count, then stops
        if (!loop_en && state != st_off)
        begin
            if (state == st_capture && edges != 2'h0)
            begin
                do_step = 1'b1;
                step_cnt = count;
            end
            next_state = st_off;
            next_short_en = 1'b1;
            next_count = `COUNT_ZERO;
        end
        // One step of modulation, borrowing from or carrying into the tap
        if (do_step)
        begin
            next_pulse = 1'b1;
            if (step_cnt < i_target_count)
            begin
                if (modf == `MOD_MAX)
                begin
                    next_modf = `MOD_RESET;
                    if (tap != `TAP_MAX)
                        next_tap = tap + 5'h01;
                end
                else
                    next_modf = modf + 5'h01;
            end
            else if (step_cnt > i_target_count)
            begin
                if (modf == `MOD_RESET)
                begin
                    next_modf = `MOD_MAX;
                    if (tap != `TAP_MIN)
                        next_tap = tap - 5'h01;
                end
                else
                    next_modf = modf - 5'h01;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= st_off;
            edges <= 2'h0;
            count <= `COUNT_ZERO;
            last <= `COUNT_ZERO;
            tap <= `TAP_RESET;
            modf <= `MOD_RESET;
            pulse <= 1'b0;
            short_en <= 1'b0;
        end
        else
        begin
            state <= next_state;
            edges <= next_edges;
            count <= next_count;
            last <= next_last;
            tap <= next_tap;
            modf <= next_modf;
            pulse <= next_pulse;
            short_en <= next_short_en;
        end
    end

    assign o_oscillator_tap_field = tap;
    assign o_oscillator_modulation_field = modf;
    assign o_last_count = last;
    assign o_correction_pulse = pulse;
    assign o_short_enable = short_en;

    // Off in mode one always
    low_power_mode_one_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_power_mode == `PM_LOW_POWER_MODE_ONE |=> state == st_off)
        else $error("loop not off in mode one");
    deep_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_power_mode == `PM_LPM3 && i_clock_generator_off_bit)
        |-> !o_loop_enabled)
        else $error("loop on with generator off");
    timer_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_power_mode == `PM_LOW_POWER_MODE_ZERO && i_timer_on_osc_clock)
        |-> o_loop_enabled && o_oscillator_enabled)
        else $error("loop off with timer on oscillator clock");
    start_now_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (state == st_off && loop_en) |=> state == st_capture)
        else $error("loop did not start at once");
    fields_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !pulse |-> $stable(tap) && $stable(modf))
        else $error("fields moved without correction");
    pulse_phase_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        pulse |-> $past(state) == st_apply ||
        ($past(state) == st_capture && !$past(loop_en)))
        else $error("correction outside apply phase");
    capture_two_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (state == st_capture && next_state == st_apply)
        |-> ref_rise && edges == 2'h1)
        else $error("capture ended early");
    short_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (state == st_capture && !loop_en) |=> short_en)
        else $error("short enable not flagged");
    drift_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (state == st_capture && edges != 2'h0 && !loop_en) |=> pulse)
        else $error("partial capture did not correct");
    cover_drift_c: cover property (@(posedge i_clk_sys)
        state == st_capture && edges != 2'h0 && !loop_en);
    cover_correct_c: cover property (@(posedge i_clk_sys) pulse);
    cover_short_c: cover property (@(posedge i_clk_sys)
        state == st_capture && !loop_en);
    cover_low_power_mode_zero_c: cover property (@(posedge i_clk_sys)
        i_power_mode == `PM_LOW_POWER_MODE_ZERO && loop_en);
endmodule : fll_dco_lock_loop

// file: src/fll_dco_pkg.sv
package fll_dco_pkg;
    typedef enum logic [1:0] {
        power_active,
        power_low_power_mode_zero,
        power_low_power_mode_one,
        power_deep
    } mode_class_t;
    typedef enum {
        st_off,
        st_wait_first,
        st_capture,
        st_apply
    } loop_state_t;
    typedef logic [2:0] power_mode_t;
endpackage : fll_dco_pkg

// file: src/fll_dco_regs.svh
`ifndef FLL_DCO_REGS_SVH
`define FLL_DCO_REGS_SVH
// Low-power mode encodings on i_power_mode
`define PM_ACTIVE 3'h0
`define PM_LOW_POWER_MODE_ZERO 3'h1
`define PM_LOW_POWER_MODE_ONE 3'h2
`define PM_LOW_POWER_MODE_TWO 3'h3
`define PM_LPM3 3'h4
`define PM_LPM4 3'h5
// Reference edges spent capturing, then applying
`define CAPTURE_EDGES 2'h2
`define APPLY_EDGES 2'h1
// Reset values and limits of the oscillator fields, and count steps
`define TAP_RESET 5'h10
`define MOD_RESET 5'h00
`define TAP_MAX 5'h1f
`define TAP_MIN 5'h00
`define MOD_MAX 5'h1f
`define COUNT_ONE 16'h0001
`define COUNT_ZERO 16'h0000
`endif
